// *** rtl/usb_device_common_regs.sv ***
// common register logic of a full/low-speed usb device: control, address, status, frame number, irq enables
// assumes an axi4-lite master, and a protocol engine that gives one-cycle event pulses on ref_clk
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "usb_device_common_cfg.svh"

module usb_device_common_regs #(
  parameter int ADDR_W = 10
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              busReset,
  input  wire logic [1:0]        bus_line_level,
  input  wire logic              resumeDone,
  input  wire logic              sofValid,
  input  wire logic [10:0]       sofFrame,
  input  wire logic              sofCrcErr,
  input  wire logic              msofValid,
  input  wire logic [2:0]        msofMicro,
  input  wire logic              msofCrcErr,
  input  wire logic              lpmSuspEvt,
  input  wire logic              lpmNyetEvt,
  input  wire logic              ramFaultEvt,
  output logic [1:0]             speedSelect,
  output logic                   resumeRequest,
  output logic                   pullupDisable,
  output logic [6:0]             activeAddr,
  output logic                   irq
);

  // ***************************
  // state
  // ***************************
  usb_device_common_pkg::state_t s_reg;
  usb_device_common_pkg::state_t s_next;

  logic [7:0]  wrIdx;
  logic [7:0]  rdIdx;
  logic        wrHs;
  logic [15:0] wdMasked;
  logic [9:0]  evtSet;

  assign wrIdx    = awaddr[9:2];
  assign rdIdx    = araddr[9:2];
  assign wrHs     = awvalid && awready && wvalid && wready;
  assign wdMasked = wdata[15:0] & {{8{wstrb[1]}}, {8{wstrb[0]}}};

  // one generate loop places each event on its flag position
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_evt
      if (gi == `IRQ_LPM_SUSP_BIT) begin : g_susp
        assign evtSet[gi] = lpmSuspEvt;
      end else if (gi == `IRQ_LPM_NYET_BIT) begin : g_nyet
        assign evtSet[gi] = lpmNyetEvt;
      end else if (gi == `IRQ_RAM_BIT) begin : g_ram
        assign evtSet[gi] = ramFaultEvt;
      end else if (gi == `IRQ_SOF_BIT) begin : g_sof
        assign evtSet[gi] = sofValid || msofValid;
      end else begin : g_none
        assign evtSet[gi] = 1'b0;
      end
    end
  endgenerate

  // ***************************
  // next state
  // ***************************
  always_comb begin
    s_next = s_reg;
    // write channel: both address and data are waited for, so their order is free
    case (s_reg.wrSt)
      usb_device_common_pkg::BUS_IDLE: begin
        if (awvalid && wvalid) begin
          s_next.awready = 1'b1;
          s_next.wready  = 1'b1;
          s_next.wrSt    = usb_device_common_pkg::BUS_ACK;
        end
      end
      usb_device_common_pkg::BUS_ACK: begin
        s_next.awready = 1'b0;
        s_next.wready  = 1'b0;
        s_next.bvalid  = 1'b1;
        s_next.bresp   = `RESP_OKAY;
        s_next.wrSt    = usb_device_common_pkg::BUS_RESP;
        // resume done drops the request before a fresh write may raise it again
        if (resumeDone) begin
          s_next.upstream_resume_request = 1'b0;
        end
        case (wrIdx)
          `IDX_CTRL_B: begin
            if (wstrb[0]) begin
              s_next.speedSel = wdata[`CTRL_SPEED_LSB +: 2];
              s_next.detach   = wdata[`CTRL_DETACH_BIT];
              if (wdata[`CTRL_RESUME_BIT]) begin
                s_next.upstream_resume_request = 1'b1;
              end
            end
          end
          `IDX_DEV_ADDR: begin
            if (wstrb[0]) begin
              s_next.devAddr = wdata[6:0];
              s_next.addrEn  = wdata[`DEVICE_ADDR_FIELD_EN_BIT];
            end
          end
          `IDX_IRQ_EN_CLR: s_next.irqEn = s_reg.irqEn & ~(wdMasked[9:0] & `IRQ_IMPL_MASK);
          `IDX_IRQ_EN_SET: s_next.irqEn = s_reg.irqEn | (wdMasked[9:0] & `IRQ_IMPL_MASK);
          `IDX_IRQ_FLAG:   s_next.irqStat = s_reg.irqStat & ~wdMasked[9:0];
          `IDX_BUS_STATUS, `IDX_FRAME_NUM: s_next.bresp = `RESP_OKAY;
          default:         s_next.bresp = `RESP_SLVERR;
        endcase
      end
      usb_device_common_pkg::BUS_RESP: begin
        if (bready) begin
          s_next.bvalid = 1'b0;
          s_next.wrSt   = usb_device_common_pkg::BUS_IDLE;
        end
      end
      default: s_next.wrSt = usb_device_common_pkg::BUS_IDLE;
    endcase
    if (s_reg.wrSt != usb_device_common_pkg::BUS_ACK && resumeDone) begin
      s_next.upstream_resume_request = 1'b0;
    end

    // read channel: data is sampled at the address handshake, so a word is coherent
    case (s_reg.rdSt)
      usb_device_common_pkg::BUS_IDLE: begin
        if (arvalid) begin
          s_next.arready = 1'b1;
          s_next.rdSt    = usb_device_common_pkg::BUS_ACK;
        end
      end
      usb_device_common_pkg::BUS_ACK: begin
        s_next.arready = 1'b0;
        s_next.rvalid  = 1'b1;
        s_next.rresp   = `RESP_OKAY;
        s_next.rdSt    = usb_device_common_pkg::BUS_RESP;
        case (rdIdx)
          `IDX_CTRL_B:     s_next.rdata = {28'h000_0000, s_reg.speedSel, s_reg.upstream_resume_request, s_reg.detach};
          `IDX_DEV_ADDR:   s_next.rdata = {24'h00_0000, s_reg.addrEn, s_reg.devAddr};
          `IDX_BUS_STATUS: s_next.rdata = {24'h00_0000, s_reg.lineLvl, 2'b00,
                                           (s_reg.speedSel == `SPD_LOW) ? `SPD_LOW : `SPD_FULL, 2'b00};
          `IDX_FRAME_NUM:  s_next.rdata = {16'h0000, s_reg.frame_crc_fault, 1'b0, s_reg.frameNum, s_reg.microNum};
          `IDX_IRQ_EN_CLR, `IDX_IRQ_EN_SET: s_next.rdata = {22'h00_0000, s_reg.irqEn};
          `IDX_IRQ_FLAG:   s_next.rdata = {22'h00_0000, s_reg.irqStat};
          default: begin
            s_next.rdata = 32'h0000_0000;
            s_next.rresp = `RESP_SLVERR;
          end
        endcase
      end
      usb_device_common_pkg::BUS_RESP: begin
        if (rready) begin
          s_next.rvalid = 1'b0;
          s_next.rdSt   = usb_device_common_pkg::BUS_IDLE;
        end
      end
      default: s_next.rdSt = usb_device_common_pkg::BUS_IDLE;
    endcase

    // ***************************
    // link side capture
    // ***************************
    s_next.lineLvl = bus_line_level;
    if (sofValid) begin
      s_next.frameNum = sofFrame;
      s_next.microNum = 3'h0;
      s_next.frame_crc_fault   = sofCrcErr;
    end else if (msofValid) begin
      s_next.microNum = msofMicro;
      s_next.frame_crc_fault   = msofCrcErr;
    end
    // a new event beats a clear written in the same cycle
    s_next.irqStat = (s_next.irqStat | evtSet) & `IRQ_IMPL_MASK;
    // bus reset dominates a software write of the address or resume request in the same cycle
    if (busReset) begin
      s_next.addrEn   = 1'b0;
      s_next.devAddr  = 7'h00;
      s_next.upstream_resume_request    = 1'b0;
      s_next.frame_crc_fault   = 1'b0;
      s_next.frameNum = 11'h000;
      s_next.microNum = 3'h0;
    end
    s_next.activeAddr = s_next.addrEn ? s_next.devAddr : 7'h00;
    s_next.irq        = |(s_next.irqStat & s_next.irqEn);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg          <= '0;
      s_reg.detach   <= `DETACH_RESET;
      s_reg.speedSel <= `SPD_LOW;
    end else begin
      s_reg <= s_next;
    end
  end

  // ***************************
  // outputs
  // ***************************
  assign awready       = s_reg.awready;
  assign wready        = s_reg.wready;
  assign bvalid        = s_reg.bvalid;
  assign bresp         = s_reg.bresp;
  assign arready       = s_reg.arready;
  assign rvalid        = s_reg.rvalid;
  assign rresp         = s_reg.rresp;
  assign rdata         = s_reg.rdata;
  assign speedSelect   = s_reg.speedSel;
  assign resumeRequest = s_reg.upstream_resume_request;
  assign pullupDisable = s_reg.detach;
  assign activeAddr    = s_reg.activeAddr;
  assign irq           = s_reg.irq;

  // ***************************
  // assertions
  // ***************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence ctrlWrite;
    wrHs && wrIdx == `IDX_CTRL_B && wstrb[0];
  endsequence
  sequence addrWrite;
    wrHs && wrIdx == `IDX_DEV_ADDR && wstrb[0] && !busReset;
  endsequence
  sequence ramEnable;
    wrHs && wrIdx == `IDX_IRQ_EN_SET && wstrb[0] && wdata[`IRQ_RAM_BIT];
  endsequence

  speed_select_a: assert property (ctrlWrite |=> speedSelect == $past(wdata[3:2]))
    else $error("speed select not taken from write");
  resume_set_a: assert property (ctrlWrite ##0 (wdata[1] && !busReset) |=> resumeRequest)
    else $error("resume request not raised");
  resume_clear_a: assert property ((busReset || (resumeDone && !wrHs)) |=> !resumeRequest)
    else $error("resume request not cleared");
  detach_hold_a: assert property ($changed(pullupDisable) |-> $past(wrHs && wrIdx == `IDX_CTRL_B))
    else $error("detach changed without a write");
  addr_active_a: assert property (addrWrite ##0 wdata[7] |=> activeAddr == $past(wdata[6:0]))
    else $error("programmed address not active");
  addr_reset_a: assert property (busReset |=> activeAddr == 7'h00 && s_reg.devAddr == 7'h00)
    else $error("bus reset left an address");
  frame_load_a: assert property ((sofValid && !busReset) |=> s_reg.frameNum == $past(sofFrame)
                                 && s_reg.microNum == 3'h0)
    else $error("frame number not captured");
  micro_load_a: assert property ((msofValid && !sofValid && !busReset) |=> s_reg.microNum == $past(msofMicro))
    else $error("sub-frame number not captured");
  crc_sync_a: assert property ($rose(s_reg.frame_crc_fault) |-> $past(sofValid || msofValid) && s_reg.irqStat[2])
    else $error("crc fault moved without frame flag");
  crc_clear_a: assert property (busReset |=> !s_reg.frame_crc_fault)
    else $error("crc fault survived bus reset");
  ram_irq_a: assert property ((ramFaultEvt && s_reg.irqEn[7] && !(wrHs && wrIdx == `IDX_IRQ_EN_CLR)) |=> irq)
    else $error("enabled ram fault gave no irq");
  en_clear_a: assert property ((wrHs && wrIdx == `IDX_IRQ_EN_CLR && wstrb[0] && wdata[7]) |=> !s_reg.irqEn[7])
    else $error("enable not cleared");
  en_set_a: assert property (ramEnable |=> s_reg.irqEn[7])
    else $error("enable not set");
  resv_read_a: assert property (rvalid |-> rdata[31:16] == 16'h0000 && !(rdIdx == `IDX_FRAME_NUM && rdata[14]))
    else $error("reserved bits read nonzero");

endmodule

// *** pkg/usb_device_common_cfg.svh ***
// offsets, field positions, reset values and codes of the common device registers
// assumes byte address = 4 * register index on a 32-bit AXI4-Lite bus
`ifndef USB_DEVICE_COMMON_CFG_SVH
`define USB_DEVICE_COMMON_CFG_SVH

// ***************************
// register indices
// ***************************
`define IDX_CTRL_B        8'h08
`define IDX_DEV_ADDR      8'h0A
`define IDX_BUS_STATUS    8'h0C
`define IDX_FRAME_NUM     8'h10
`define IDX_IRQ_EN_CLR    8'h14
`define IDX_IRQ_EN_SET    8'h18
`define IDX_IRQ_FLAG      8'h1C

// ***************************
// fields and reset values
// ***************************
`define CTRL_DETACH_BIT   0
`define CTRL_RESUME_BIT   1
`define CTRL_SPEED_LSB    2
`define DEVICE_ADDR_FIELD_EN_BIT       7
`define SPD_LOW           2'h0
`define SPD_FULL          2'h1
`define CTRL_RESET        16'h0001
`define DETACH_RESET      1'b1
`define IRQ_LPM_SUSP_BIT  9
`define IRQ_LPM_NYET_BIT  8
`define IRQ_RAM_BIT       7
`define IRQ_SOF_BIT       2
`define IRQ_IMPL_MASK     10'h384
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// *** pkg/usb_device_common_pkg.sv ***
// types of the common device register block
// assumes nothing beyond the cfg header for its numbers
package usb_device_common_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK  = 2'h1,
    BUS_RESP = 2'h3
  } bus_state_t;

  typedef struct packed {
    bus_state_t  wrSt;
    bus_state_t  rdSt;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [1:0]  speedSel;
    logic        upstream_resume_request;
    logic        detach;
    logic [6:0]  devAddr;
    logic        addrEn;
    logic [6:0]  activeAddr;
    logic [1:0]  lineLvl;
    logic        frame_crc_fault;
    logic [10:0] frameNum;
    logic [2:0]  microNum;
    logic [9:0]  irqEn;
    logic [9:0]  irqStat;
    logic        irq;
  } state_t;

endpackage

// *** verif/usb_host_model.sv ***
// far side of the register block: usb protocol engine events seen from the host
// assumes the bench calls its tasks and that ref_clk runs free
`timescale 1ns/1ps

module usb_host_model (
  input  wire logic        ref_clk,
  output logic [4:0]       pv,
  output logic [1:0]       bus_line_level,
  output logic             sofValid,
  output logic [10:0]      sofFrame,
  output logic             sofCrcErr,
  output logic             msofValid,
  output logic [2:0]       msofMicro,
  output logic             msofCrcErr
);
  // ******************
  // packet drivers
  // ******************
  // pv: 0 bus reset, 1 resume done, 2 ram fault, 3 lpm nyet, 4 lpm suspend
  initial begin
    pv = '0;
    bus_line_level = 2'h1;
    {sofValid, sofFrame, sofCrcErr, msofValid, msofMicro, msofCrcErr} = '0;
  end
  task automatic strobe(input int i);
    @(posedge ref_clk);
    pv[i] <= 1'b1;
    @(posedge ref_clk);
    pv[i] <= 1'b0;
  endtask
  // idle payload flips so stale values cannot pass
  task automatic sof(input logic [10:0] f, input logic e);
    @(posedge ref_clk);
    {sofValid, sofFrame, sofCrcErr} <= {1'b1, f, e};
    @(posedge ref_clk);
    {sofValid, sofFrame, sofCrcErr} <= {1'b0, ~f, ~e};
  endtask
  task automatic msof(input logic [2:0] m, input logic e);
    @(posedge ref_clk);
    {msofValid, msofMicro, msofCrcErr} <= {1'b1, m, e};
    @(posedge ref_clk);
    {msofValid, msofMicro, msofCrcErr} <= {1'b0, ~m, ~e};
  endtask
endmodule

// *** verif/tb_usb_device_common_regs.sv ***
// bench of the common device registers over axi4-lite
// assumes the host model drives all link inputs
`timescale 1ns/1ps
`include "usb_device_common_cfg.svh"

module tb_usb_device_common_regs;
  localparam logic [9:0] A_CTRL = 10'h020, A_ADDR = 10'h028, A_STAT = 10'h030, A_FRM = 10'h040;
  localparam logic [9:0] A_CLR = 10'h050, A_SET = 10'h060, A_FLAG = 10'h070;
  logic        ref_clk = 0, rst_b = 0;
  logic [9:0]  awaddr = '0, araddr = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata, lastRd;
  logic        awready, wready, bvalid, arready, rvalid, resumeRequest, pullupDisable, irq;
  logic [1:0]  bresp, rresp, speedSelect, lastB, lastR;
  logic [6:0]  activeAddr;
  logic [3:0]  wstrb = 4'hF;
  logic [4:0]  pv;
  logic [1:0]  bus_line_level;
  logic        sofValid, sofCrcErr, msofValid, msofCrcErr;
  logic [10:0] sofFrame;
  logic [2:0]  msofMicro;
  int          n_fail = 0, tests_run = 0;

  always #50 ref_clk = ~ref_clk;

  usb_host_model HOST (.ref_clk(ref_clk), .pv(pv), .bus_line_level(bus_line_level), .sofValid(sofValid),
    .sofFrame(sofFrame), .sofCrcErr(sofCrcErr), .msofValid(msofValid), .msofMicro(msofMicro),
    .msofCrcErr(msofCrcErr));

  usb_device_common_regs DUT (.ref_clk(ref_clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .busReset(pv[0]),
    .bus_line_level(bus_line_level), .resumeDone(pv[1]), .sofValid(sofValid), .sofFrame(sofFrame),
    .sofCrcErr(sofCrcErr), .msofValid(msofValid), .msofMicro(msofMicro), .msofCrcErr(msofCrcErr),
    .lpmSuspEvt(pv[4]), .lpmNyetEvt(pv[3]), .ramFaultEvt(pv[2]), .speedSelect(speedSelect),
    .resumeRequest(resumeRequest), .pullupDisable(pullupDisable), .activeAddr(activeAddr), .irq(irq));

  // ******************
  // bus tasks
  // ******************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    lastB = bresp;
    bready <= 1'b0;
    #1;
  endtask
  task automatic rdck(input logic [9:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    {lastRd, lastR} = {rdata, rresp};
    rready <= 1'b0;
    chk(lastRd, exp);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ******************
  // tests
  // ******************
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdck(A_CTRL, `CTRL_RESET);
    chk(pullupDisable, 1);
    rdck(A_FRM, 0);
    wr(A_CTRL, 32'h0000_0004);
    chk({speedSelect, pullupDisable}, 3'b010);
    for (int i = 0; i < 3; i++) begin
      HOST.bus_line_level <= 2'(i);
      rdck(A_STAT, (i << 6) | 32'h4);
    end
    wr(A_CTRL, 0);
    rdck(A_STAT, 32'h80);
    // low lane strobe off: control fields must not move
    wstrb <= 4'h2;
    wr(A_CTRL, 32'h0000_0001);
    wstrb <= 4'hF;
    rdck(A_CTRL, 0);
    // resume request: zero write keeps it, done pulse or bus reset drops it
    wr(A_CTRL, 32'h0000_0006);
    chk(resumeRequest, 1);
    wr(A_CTRL, 32'h0000_0004);
    chk(resumeRequest, 1);
    HOST.strobe(1);
    #1 chk(resumeRequest, 0);
    wr(A_CTRL, 32'h0000_0006);
    HOST.strobe(0);
    #1 chk(resumeRequest, 0);
    wr(A_ADDR, 32'h0000_0085);
    chk(activeAddr, 7'h05);
    rdck(A_ADDR, 32'h85);
    wr(A_ADDR, 32'h0000_0005);
    chk(activeAddr, 0);
    wr(A_ADDR, 32'h0000_00AA);
    chk(activeAddr, 7'h2A);
    HOST.strobe(0);
    rdck(A_ADDR, 0);
    chk(activeAddr, 0);
    HOST.sof(11'h5A3, 0);
    rdck(A_FRM, 32'h2D18);
    rdck(A_FLAG, 32'h4);
    HOST.msof(3'h5, 1);
    rdck(A_FRM, 32'hAD1D);
    HOST.sof(11'h7FF, 1);
    rdck(A_FRM, 32'hBFF8);
    wr(A_FRM, 32'h0000_FFFF);
    chk(lastB, `RESP_OKAY);
    rdck(A_FRM, 32'hBFF8);
    HOST.sof(11'h123, 0);
    rdck(A_FRM, 32'h0918);
    HOST.msof(3'h2, 0);
    HOST.strobe(0);
    rdck(A_FRM, 0);
    wr(A_FLAG, 32'h0000_0004);
    wr(A_SET, 32'h0000_0380);
    rdck(A_CLR, 32'h380);
    for (int i = 0; i < 3; i++) begin
      HOST.strobe(i + 2);
      #1 chk(irq, 1);
      wr(A_FLAG, 32'h1 << (i + 7));
      chk(irq, 0);
    end
    wr(A_CLR, 32'h0000_0200);
    rdck(A_SET, 32'h180);
    wr(A_SET, 0);
    wr(A_CLR, 0);
    rdck(A_CLR, 32'h180);
    HOST.strobe(4);
    #1 chk(irq, 0);
    rdck(A_FLAG, 32'h200);
    rdck(10'h3FC, 0);
    chk(lastR, `RESP_SLVERR);
    wr(10'h3FC, 32'h0000_FFFF);
    chk(lastB, `RESP_SLVERR);
    // reset in mid-run restores the detached default
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdck(A_CTRL, `CTRL_RESET);
    chk({speedSelect, pullupDisable}, 3'b001);
    report_and_stop;
  end

  // a stuck handshake ends the run here
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    report_and_stop;
  end
endmodule
